// *** hw/dpll_ref_cfg.svh ***
// constants for the dpll reference configuration block
`ifndef DPLL_REF_CFG_SVH
`define DPLL_REF_CFG_SVH

// =====================================================================
// register map (host word addresses)
`define ADDR_DPLL_CONTROL     16'h0040
`define ADDR_REF_FREQ_SELECT  16'h0041
`define RESET_DPLL_CONTROL    16'h0000
`define RESET_REF_FREQ_SELECT 16'h0000
`define MASK_DPLL_CONTROL     16'h0023
`define MASK_REF_FREQ_SELECT  16'h0FFF

// =====================================================================
// dpll_control fields
`define BIT_RESET_HOLD        0
`define BIT_OVERRIDE_ENABLE   1
`define BIT_STRATUM_LIMIT     5

// =====================================================================
// ref_freq_select fields: low bit of each 3-bit code, input n at 3*n
`define FREQ_CODE_WIDTH       3
`define FREQ_CODE_STRIDE      3

// =====================================================================
// frequency codes and their nominal values in Hz
`define CODE_8K               3'h0
`define CODE_1544K            3'h1
`define CODE_2048K            3'h2
`define CODE_4096K            3'h3
`define CODE_8192K            3'h4
`define CODE_16384K           3'h5
`define CODE_19440K           3'h6
`define CODE_RESERVED         3'h7
`define HZ_8K                 25'd8000
`define HZ_1544K              25'd1544000
`define HZ_2048K              25'd2048000
`define HZ_4096K              25'd4096000
`define HZ_8192K              25'd8192000
`define HZ_16384K             25'd16384000
`define HZ_19440K             25'd19440000

// =====================================================================
// monitoring limits in thousandths of a ppm
`define STRICT_ACCEPT_MPPM    18'd64713
`define STRICT_REJECT_MPPM    18'd82487
`define RELAXED_ACCEPT_MPPM   18'd240000
`define RELAXED_REJECT_MPPM   18'd250000

// =====================================================================
// timing
`define CLK_FREQ_HZ           125000000
`define MONITOR_INTERVAL_S    10
`define MONITOR_INTERVAL_CYC  (`MONITOR_INTERVAL_S * `CLK_FREQ_HZ)

`endif

// *** hw/dpll_ref_pkg.sv ***
// types for the dpll reference configuration block
package dpll_ref_pkg;

  typedef logic [2:0]  freq_code_t;
  typedef logic [15:0] host_word_t;
  typedef logic [24:0] freq_hz_t;
  typedef logic [17:0] limit_mppm_t;

  typedef enum logic {
    LIMIT_RELAXED,
    LIMIT_STRICT
  } limit_mode_t;

endpackage

// *** hw/ref_code_select.sv ***
// per-reference frequency code selection and decode
`timescale 1ns/10ps
`include "dpll_ref_cfg.svh"

module ref_code_select
  import dpll_ref_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       overrideEn,
  input  wire freq_code_t swCode,
  input  wire freq_code_t detCode,
  output freq_code_t      effCode,
  output freq_hz_t        effHz,
  output logic            codeReserved
);

  // =====================================================================
  // decode
  function automatic freq_hz_t codeToHz(input freq_code_t code);
    case (code)
      `CODE_8K:     codeToHz = `HZ_8K;
      `CODE_1544K:  codeToHz = `HZ_1544K;
      `CODE_2048K:  codeToHz = `HZ_2048K;
      `CODE_4096K:  codeToHz = `HZ_4096K;
      `CODE_8192K:  codeToHz = `HZ_8192K;
      `CODE_16384K: codeToHz = `HZ_16384K;
      `CODE_19440K: codeToHz = `HZ_19440K;
      default:      codeToHz = 25'h0;
    endcase
  endfunction

  freq_code_t selCode;

  // software code only counts while override is on
  assign selCode = overrideEn ? swCode : detCode;

  // =====================================================================
  // registered outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      effCode      <= `CODE_8K;
      effHz        <= `HZ_8K;
      codeReserved <= 1'b0;
    end else begin
      effCode      <= selCode;
      effHz        <= codeToHz(selCode);
      // reserved code yields 0 Hz and a flag rather than a guess
      codeReserved <= (selCode == `CODE_RESERVED);
    end
  end

endmodule

// *** hw/dpll_reference_config.sv ***
// dpll reference configuration: control registers, code select, limits
`timescale 1ns/10ps
`include "dpll_ref_cfg.svh"
// Behaviour
// - with the stratum limit bit set, monitoring uses 64.713/82.487 ppm over 10 s.
// - with the stratum limit bit clear, monitoring uses 240/250 ppm over 10 s.
// - with override clear, each reference takes its frequency from its detector.
// - with override set, each reference takes its frequency from ref_freq_select.
// - bits 11-9 give reference input 3's code, only while override is set.
// - bits 8-6 give reference input 2's code, only while override is set.
// - bits 5-3 give input 1's and bits 2-0 input 0's code, only under override.
// - codes decode 8k, 1.544M, 2.048M, 4.096M, 8.192M, 16.384M, 19.44M, reserved.

module dpll_reference_config
  import dpll_ref_pkg::*;
#(
  parameter int unsigned NUM_REFS         = 4,
  parameter int unsigned INTERVAL_CYCLES  = `MONITOR_INTERVAL_CYC
)(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [15:0]           hostAddr,
  input  wire logic                  hostWrEn,
  input  wire logic                  hostRdEn,
  input  wire logic [15:0]           hostWrData,
  output logic [15:0]                hostRdData,
  output logic                       hostRdValid,
  input  wire logic [3*NUM_REFS-1:0] detCodes,
  output logic [3*NUM_REFS-1:0]      effCodes,
  output logic [25*NUM_REFS-1:0]     effHz,
  output logic [NUM_REFS-1:0]        codeReserved,
  output logic                       dpllResetHold,
  output logic                       strictLimits,
  output logic [17:0]                acceptLimitMppm,
  output logic [17:0]                rejectLimitMppm,
  output logic                       intervalTick
);

  // =====================================================================
  // registers
  host_word_t dpllControl_reg;
  host_word_t refFreqSelect_reg;

  function automatic logic hitAddr(input logic [15:0] a, input logic [15:0] target);
    hitAddr = (a == target);
  endfunction

  // =====================================================================
  // host strobe decode
  logic wrControl;
  logic wrFreqSelect;
  logic rdControl;
  logic rdFreqSelect;

  assign wrControl    = hostWrEn && hitAddr(hostAddr, `ADDR_DPLL_CONTROL);
  assign wrFreqSelect = hostWrEn && hitAddr(hostAddr, `ADDR_REF_FREQ_SELECT);
  assign rdControl    = hostRdEn && hitAddr(hostAddr, `ADDR_DPLL_CONTROL);
  assign rdFreqSelect = hostRdEn && hitAddr(hostAddr, `ADDR_REF_FREQ_SELECT);

  // reserved bits are masked at write time, so they read back as zero
  // even if software breaks the write-zero convention
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dpllControl_reg <= `RESET_DPLL_CONTROL;
    end else if (wrControl) begin
      dpllControl_reg <= hostWrData & `MASK_DPLL_CONTROL;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refFreqSelect_reg <= `RESET_REF_FREQ_SELECT;
    end else if (wrFreqSelect) begin
      refFreqSelect_reg <= hostWrData & `MASK_REF_FREQ_SELECT;
    end
  end

  // =====================================================================
  // read port: one cycle latency, unmapped reads give zero with valid set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hostRdValid <= 1'b0;
    end else begin
      hostRdValid <= hostRdEn;
    end
  end

  // data is zero outside a read so a stale word never lingers on the bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hostRdData <= 16'h0000;
    end else if (rdControl) begin
      hostRdData <= dpllControl_reg;
    end else if (rdFreqSelect) begin
      hostRdData <= refFreqSelect_reg;
    end else begin
      hostRdData <= 16'h0000;
    end
  end

  // =====================================================================
  // control outputs
  logic overrideEn;
  logic strictSel;

  assign overrideEn = dpllControl_reg[`BIT_OVERRIDE_ENABLE];
  assign strictSel  = dpllControl_reg[`BIT_STRATUM_LIMIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dpllResetHold <= 1'b0;
    end else begin
      dpllResetHold <= dpllControl_reg[`BIT_RESET_HOLD];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strictLimits <= 1'b0;
    end else begin
      strictLimits <= strictSel;
    end
  end

  // limits follow the select bit one edge later, together with the flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acceptLimitMppm <= `RELAXED_ACCEPT_MPPM;
    end else if (strictSel) begin
      acceptLimitMppm <= `STRICT_ACCEPT_MPPM;
    end else begin
      acceptLimitMppm <= `RELAXED_ACCEPT_MPPM;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rejectLimitMppm <= `RELAXED_REJECT_MPPM;
    end else if (strictSel) begin
      rejectLimitMppm <= `STRICT_REJECT_MPPM;
    end else begin
      rejectLimitMppm <= `RELAXED_REJECT_MPPM;
    end
  end

  // =====================================================================
  // monitoring interval: one pulse per interval; held off while the
  // dpll is in reset hold so a fresh interval starts on release
  logic [31:0] intervalCount_reg;
  logic        intervalDone;

  assign intervalDone = (intervalCount_reg == INTERVAL_CYCLES - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intervalCount_reg <= 32'h00000000;
    end else if (dpllResetHold || intervalDone) begin
      intervalCount_reg <= 32'h00000000;
    end else begin
      intervalCount_reg <= intervalCount_reg + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intervalTick <= 1'b0;
    end else begin
      intervalTick <= intervalDone && !dpllResetHold;
    end
  end

  // =====================================================================
  // per-reference source selection; field n sits at bits 3n+2..3n
  // (input 3 at 11-9, input 2 at 8-6, input 1 at 5-3, input 0 at 2-0)
  genvar g;
  generate
    for (g = 0; g < NUM_REFS; g++) begin : gen_ref
      ref_code_select u_sel (
        .clk          (clk),
        .nrst         (nrst),
        .overrideEn   (overrideEn),
        .swCode       (refFreqSelect_reg[`FREQ_CODE_STRIDE*g +: `FREQ_CODE_WIDTH]),
        .detCode      (detCodes[3*g +: 3]),
        .effCode      (effCodes[3*g +: 3]),
        .effHz        (effHz[25*g +: 25]),
        .codeReserved (codeReserved[g])
      );
    end
  endgenerate

endmodule

// *** bench/ref_hz_fn.svh ***
// nominal frequency of reference codes, 0 for the reserved code
function automatic logic [24:0] codeHz(input logic [2:0] c);
  case (c)
    3'h0: return 25'h1F40;
    3'h1: return 25'h178F40;
    3'h2: return 25'h1F4000;
    3'h3: return 25'h3E8000;
    3'h4: return 25'h7D0000;
    3'h5: return 25'hFA0000;
    3'h6: return 25'h128A180;
    default: return 25'h0;
  endcase
endfunction

function automatic logic [99:0] allHz(input logic [11:0] c);
  return {codeHz(c[11:9]), codeHz(c[8:6]), codeHz(c[5:3]), codeHz(c[2:0])};
endfunction

// *** bench/dpll_reference_config_chk.sv ***
// port assertions of the dpll reference configuration
`timescale 1ns/10ps
module dpll_reference_config_chk #(
  parameter int unsigned NUM_REFS        = 4,
  parameter int unsigned INTERVAL_CYCLES = 20
)(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] hostAddr,
  input wire logic        hostWrEn,
  input wire logic        hostRdEn,
  input wire logic [15:0] hostWrData,
  input wire logic [15:0] hostRdData,
  input wire logic        hostRdValid,
  input wire logic [11:0] detCodes,
  input wire logic [11:0] effCodes,
  input wire logic [99:0] effHz,
  input wire logic [3:0]  codeReserved,
  input wire logic        dpllResetHold,
  input wire logic        strictLimits,
  input wire logic [17:0] acceptLimitMppm,
  input wire logic [17:0] rejectLimitMppm,
  input wire logic        intervalTick
);
`include "ref_hz_fn.svh"
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // shadow of the override bit and software codes
  logic        ovr;
  logic [11:0] sw;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovr <= 1'b0;
      sw <= 12'h000;
    end else if (hostWrEn) begin
      if (hostAddr == 16'h0040) ovr <= hostWrData[1];
      if (hostAddr == 16'h0041) sw <= hostWrData[11:0];
    end
  end
  // ==========================================================
  // assertions
  strict_lim_a: assert property (strictLimits |->
    acceptLimitMppm == 18'hFCC9 && rejectLimitMppm == 18'h14237) else $error("strict limits");
  relaxed_lim_a: assert property (!strictLimits |->
    acceptLimitMppm == 18'h3A980 && rejectLimitMppm == 18'h3D090) else $error("relaxed limits");
  // the register takes the write at one edge, the outputs follow at the next
  limit_sel_a: assert property (hostWrEn && hostAddr == 16'h0040 |=> ##1
    strictLimits == $past(hostWrData[5], 2)) else $error("limit select");
  rsv_read_a: assert property (hostRdEn |=> hostRdValid && hostRdData[15:12] == 4'h0 &&
    ($past(hostAddr) != 16'h0040 || hostRdData[4:2] == 3'h0)) else $error("reserved bits");
  code_sel_a: assert property (1'b1 |=>
    effCodes == $past(ovr ? sw : detCodes)) else $error("code select");
  hz_decode_a: assert property (effHz == allHz(effCodes) && codeReserved ==
    {&effCodes[11:9], &effCodes[8:6], &effCodes[5:3], &effCodes[2:0]}) else $error("decode");
  hold_bit_a: assert property (hostWrEn && hostAddr == 16'h0040 |=> ##1
    dpllResetHold == $past(hostWrData[0], 2)) else $error("reset hold");
  hold_tick_a: assert property (dpllResetHold && $past(dpllResetHold) |->
    !intervalTick) else $error("tick under hold");
  rd_idle_a: assert property (!hostRdValid |-> hostRdData == 16'h0000) else $error("idle data");
  cover property (hostWrEn && hostAddr == 16'h0041 && ovr);
  cover property (intervalTick);
  cover property (|codeReserved);
endmodule

// *** bench/ref_detector_model.sv ***
// behavioural frequency detectors of the four reference inputs
`timescale 1ns/10ps
module ref_detector_model (
  input  wire logic [11:0] measured,
  input  wire logic        clk,
  output logic [11:0]      detCodes
);
  // a detector settles on its new code one clock after the measurement
  initial detCodes = 12'h000;
  always @(posedge clk) begin
    detCodes <= #1 measured;
  end
endmodule

// *** bench/dpll_reference_config_tb.sv ***
// self-checking bench of the dpll reference configuration
`timescale 1ns/10ps
module dpll_reference_config_tb;
`include "ref_hz_fn.svh"
  logic clk = 1'b0, nrst = 1'b0, hostWrEn = 1'b0, hostRdEn = 1'b0, hostRdValid;
  logic dpllResetHold, strictLimits, intervalTick;
  logic [15:0] hostAddr = 16'h0, hostWrData = 16'h0, hostRdData;
  logic [11:0] detNext = 12'h0, detCodes, effCodes;
  logic [99:0] effHz;
  logic [3:0]  codeReserved;
  logic [17:0] acceptLimitMppm, rejectLimitMppm;
  int failCount = 0, checksDone = 0;
  always #4 clk = ~clk;
  dpll_reference_config #(
    .INTERVAL_CYCLES (20)
  ) i_dpll_reference_config (
    .clk             (clk),
    .nrst            (nrst),
    .hostAddr        (hostAddr),
    .hostWrEn        (hostWrEn),
    .hostRdEn        (hostRdEn),
    .hostWrData      (hostWrData),
    .hostRdData      (hostRdData),
    .hostRdValid     (hostRdValid),
    .detCodes        (detCodes),
    .effCodes        (effCodes),
    .effHz           (effHz),
    .codeReserved    (codeReserved),
    .dpllResetHold   (dpllResetHold),
    .strictLimits    (strictLimits),
    .acceptLimitMppm (acceptLimitMppm),
    .rejectLimitMppm (rejectLimitMppm),
    .intervalTick    (intervalTick)
  );
  ref_detector_model i_ref_detector_model (.measured(detNext), .clk(clk), .detCodes(detCodes));
  // ==========================================================
  // tasks: entered and left just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic check(input string what, input logic [99:0] seen, input logic [99:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    hostAddr = a;
    hostWrData = d;
    hostWrEn = 1'b1;
    step(1);
    hostWrEn = 1'b0;
    // idle edge: a following request never re-raises the strobe in this time step
    step(1);
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    hostAddr = a;
    hostRdEn = 1'b1;
    step(1);
    hostRdEn = 1'b0;
    check("rdValid", hostRdValid, 1'b1);
    d = hostRdData;
    step(1);
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] v, r;
    logic [11:0] c;
    int n;
    void'($urandom(84558));
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    step(1);
    check("acceptReset", acceptLimitMppm, 18'h3A980);
    rd(16'h0040, v);
    check("ctrlReset", v, 16'h0000);
    rd(16'h0041, v);
    check("freqReset", v, 16'h0000);
    rd(16'h0042, v);
    check("unmapped", v, 16'h0000);
    wr(16'h0040, 16'hFFFF);
    step(1);
    check("strictFlag", strictLimits, 1'b1);
    check("strictAccept", acceptLimitMppm, 18'hFCC9);
    check("strictReject", rejectLimitMppm, 18'h14237);
    rd(16'h0040, v);
    check("ctrlMask", v, 16'h0023);
    check("hold", dpllResetHold, 1'b1);
    n = 0;
    repeat (30) begin
      step(1);
      if (intervalTick !== 1'b0) n++;
    end
    check("heldTicks", n[7:0], 8'h00);
    // strict stays on here so the later return to relaxed limits is visible
    wr(16'h0040, 16'h0022);
    for (int i = 0; i < 24; i++) begin
      v = (i < 8) ? {4'hF, {4{i[2:0]}}} : 16'($urandom);
      detNext = 12'($urandom);
      wr(16'h0041, v);
      step(2);
      check("swCodes", effCodes, v[11:0]);
      check("swHz", effHz, allHz(v[11:0]));
      check("swRsv", codeReserved, {&v[11:9], &v[8:6], &v[5:3], &v[2:0]});
      rd(16'h0041, r);
      check("freqMask", r, {4'h0, v[11:0]});
    end
    wr(16'h0040, 16'h0000);
    check("relaxedFlag", strictLimits, 1'b0);
    check("relaxedAccept", acceptLimitMppm, 18'h3A980);
    check("relaxedReject", rejectLimitMppm, 18'h3D090);
    for (int i = 0; i < 24; i++) begin
      c = (i < 8) ? {4{i[2:0]}} : 12'($urandom);
      detNext = c;
      wr(16'h0041, 16'($urandom) & 16'h0FFF);
      step(3);
      check("detCodes", effCodes, c);
      check("detHz", effHz, allHz(c));
      check("detRsv", codeReserved, {&c[11:9], &c[8:6], &c[5:3], &c[2:0]});
    end
    n = 0;
    while (intervalTick !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    check("tickSeen", n < 50, 1'b1);
    n = 0;
    do begin
      step(1);
      n++;
    end while (intervalTick !== 1'b1 && n < 50);
    check("tickPeriod", n[7:0], 8'h14);
    endOfTest();
  end
endmodule

bind dpll_reference_config dpll_reference_config_chk #(.NUM_REFS(NUM_REFS),
  .INTERVAL_CYCLES(INTERVAL_CYCLES)) i_dpll_reference_config_chk (.clk(clk), .nrst(nrst),
  .hostAddr(hostAddr), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostWrData(hostWrData),
  .hostRdData(hostRdData), .hostRdValid(hostRdValid), .detCodes(detCodes),
  .effCodes(effCodes), .effHz(effHz), .codeReserved(codeReserved),
  .dpllResetHold(dpllResetHold), .strictLimits(strictLimits),
  .acceptLimitMppm(acceptLimitMppm), .rejectLimitMppm(rejectLimitMppm),
  .intervalTick(intervalTick));
